//--- dv/sspi_master_model.sv
`timescale 1ns/1ps
module sspi_master_model #(
   parameter real HALF = 40.0
) (
   input  wire logic miso,
   output logic      sck,
   output logic      mosi,
   output logic      ss_n
);
   initial begin
      sck  = 1'b0;
      mosi = 1'b1;
      ss_n = 1'b1;
   end
   // n below 8 aborts the frame mid-byte
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      ss_n = 1'b0;
      #(2*HALF);
      for (int i = 7; i > 7 - n; i--) begin
         mosi = tx[i];
         #(HALF);
         sck = 1'b1;
         rx = {rx[6:0], miso};
         #(HALF);
         sck = 1'b0;
      end
      #(HALF);
      ss_n = 1'b1;
      mosi = ~mosi; // released line must not look held
   endtask
   // clock with no frame: a selected-mode slave must ignore it
   task automatic stray(input int n);
      repeat (n) begin
         #(HALF) sck = 1'b1;
         #(HALF) sck = 1'b0;
      end
   endtask
endmodule

//--- dv/sync_serial_spi_slave_test.sv
`timescale 1ns/1ps
module sync_serial_spi_slave_test;
   import sspi_pkg::*;
   logic         ref_clk = 1'b0;
   logic         rst = 1'b1;
   sspi_cfg_t    cfg;
   logic         sleep_req = 1'b0;
   logic         irq_enable = 1'b0;
   logic         sck, sdi, ss_n, sdo_out, sdo_oe, miso;
   logic         wr_valid = 1'b0;
   logic [7:0]   wr_data = 8'h00;
   logic         wr_ready, rd_valid, wake;
   logic         rd_ready = 1'b0;
   logic [7:0]   rd_data, rx;
   logic         clr_irq = 1'b0;
   logic         clr_coll = 1'b0;
   sspi_status_t status;
   int           fail_count = 0;
   int           n_checks = 0;
   int           wake_cnt = 0;

   always #2 ref_clk = ~ref_clk;
   assign miso = sdo_oe ? sdo_out : 1'b1; // pull-up when released
   always @(posedge ref_clk) if (wake === 1'b1) wake_cnt++;

   sspi_master_model m (.miso(miso), .sck(sck), .mosi(sdi), .ss_n(ss_n));
   sspi_slave uut (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .sleep_req(sleep_req),
      .irq_enable(irq_enable), .sck_in(sck), .sdi_in(sdi), .ss_n_in(ss_n),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .flag_clear_irq(clr_irq), .flag_clear_collision(clr_coll), .status(status), .wake(wake));

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge ref_clk) #1;
      wr_valid = 1'b1;
      wr_data = d;
      for (int k = 0; k < 20; k++) begin
         @(posedge ref_clk);
         if (wr_ready === 1'b1) break;
      end
      chk(wr_ready, 1'b1);
      #1 wr_valid = 1'b0;
   endtask
   task automatic pop(input logic [7:0] exp);
      @(posedge ref_clk) #1;
      rd_ready = 1'b1;
      for (int k = 0; k < 20; k++) begin
         @(posedge ref_clk);
         if (rd_valid === 1'b1) break;
      end
      chk(rd_valid, 1'b1);
      chk(rd_data, exp);
      #1 rd_ready = 1'b0;
   endtask
   task automatic pulse_clr(input bit coll);
      @(posedge ref_clk) #1;
      if (coll) clr_coll = 1'b1;
      else clr_irq = 1'b1;
      @(posedge ref_clk) #1;
      clr_coll = 1'b0;
      clr_irq = 1'b0;
      // status is registered: one more edge before it shows the clear
      @(posedge ref_clk) #1;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_basic;
      wr(8'hA5);
      fork
         m.xfer(8'h3C, 8, rx);
         begin #100; chk(sdo_oe, 1'b1); end
      join
      chk(rx, 8'hA5);
      repeat (4) @(posedge ref_clk);
      chk(status.port_irq_flag, 1'b1);
      chk(status.buffer_full_flag, 1'b1);
      pop(8'h3C);
      pulse_clr(1'b0);
   endtask
   task automatic t_daisy;
      m.xfer(8'hC3, 8, rx);
      chk(rx, 8'h3C);
      m.xfer(8'h00, 8, rx);
      chk(rx, 8'hC3);
      pop(8'hC3);
      pop(8'h00);
      repeat (2) @(posedge ref_clk);
      chk(status.buffer_full_flag, 1'b0);
   endtask
   task automatic t_collide;
      fork
         m.xfer(8'h55, 8, rx);
         begin
            #300;
            chk(status.busy, 1'b1);
            wr(8'h99);
         end
      join
      chk(status.write_collision_flag, 1'b1);
      pop(8'h55);
      pulse_clr(1'b1);
      chk(status.write_collision_flag, 1'b0);
   endtask
   task automatic t_overwrite;
      cfg.buffer_overwrite_en = 1'b1;
      m.xfer(8'h11, 8, rx);
      wr(8'hE7);
      m.xfer(8'h22, 8, rx);
      chk(rx, 8'hE7);
      pop(8'h11);
      pop(8'h22);
      cfg.buffer_overwrite_en = 1'b0;
   endtask
   task automatic t_abort;
      wr(8'hF0);
      m.xfer(8'hAA, 3, rx);
      repeat (5) @(posedge ref_clk);
      chk(sdo_oe, 1'b0);
      m.stray(5);
      // no new write: the cut byte must come back out untouched by the strays
      m.xfer(8'h5A, 8, rx);
      chk(rx, 8'h85);
      pop(8'h5A);
      wr(8'h0F);
      m.xfer(8'h5A, 8, rx);
      chk(rx, 8'h0F);
      pop(8'h5A);
   endtask
   task automatic t_sleep;
      sleep_req = 1'b1;
      irq_enable = 1'b1;
      m.xfer(8'h77, 8, rx);
      repeat (4) @(posedge ref_clk);
      chk(wake_cnt[7:0], 8'h01);
      pop(8'h77);
      sleep_req = 1'b0;
   endtask
   task automatic t_mode;
      @(posedge ref_clk) #1;
      cfg.port_mode_field = SSPI_MODE_SLAVE;
      repeat (3) @(posedge ref_clk);
      chk(sdo_oe, 1'b1);
      // select is ignored here, so a cut byte leaves the counter running
      m.xfer(8'hAA, 3, rx);
      repeat (4) @(posedge ref_clk);
      chk(status.busy, 1'b1);
      #1 cfg.port_enable_bit = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 cfg.port_enable_bit = 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(status.busy, 1'b0);
      #1 cfg.port_mode_field = SSPI_MODE_SLAVE_SS;
      repeat (3) @(posedge ref_clk);
      chk(sdo_oe, 1'b0);
   endtask

   initial begin
      cfg = '{1'b0, SSPI_MODE_SLAVE_SS, 1'b0, 1'b0, 1'b0, 1'b0};
      repeat (8) @(posedge ref_clk);
      #1 rst = 1'b0;
      cfg.port_enable_bit = 1'b1;
      t_basic;
      t_daisy;
      t_collide;
      t_overwrite;
      t_abort;
      t_sleep;
      t_mode;
      test_done;
   end
   initial begin
      #100000;
      fail_count++;
      test_done;
   end
endmodule

//--- src/sspi_pkg.sv
package sspi_pkg;
   // ------------------------------------------------------------
   // modes and widths
   // ------------------------------------------------------------
   localparam int          SSPI_DATA_W        = 8;
   localparam int          SSPI_CNT_W         = 3;
   localparam logic [3:0]  SSPI_MODE_SLAVE_SS = 4'h4;
   localparam logic [3:0]  SSPI_MODE_SLAVE    = 4'h5;
   localparam logic [2:0]  SSPI_CNT_LAST      = 3'h7;
   localparam logic [2:0]  SSPI_CNT_ZERO      = 3'h0;
   localparam logic [7:0]  SSPI_BYTE_ZERO     = 8'h00;
   localparam int          SSPI_BUF_DEPTH     = 2;

   typedef struct packed {
      logic       port_enable_bit;
      logic [3:0] port_mode_field;
      logic       clk_polarity_sel;
      logic       clk_edge_sel;
      logic       input_sample_phase;
      logic       buffer_overwrite_en;
   } sspi_cfg_t;

   typedef struct packed {
      logic port_irq_flag;
      logic buffer_full_flag;
      logic write_collision_flag;
      logic busy;
   } sspi_status_t;
endpackage

//--- src/sspi_slave.sv
`timescale 1ns/1ps
// Functional notes
// - shift only on external serial clock edges
// - set irq flag when last bit latched
// - keeps shifting during sleep, irq wakes
// - shifting not gated by system sleep state
// - daisy chain: retransmit received byte next group
// - overwrite enable lets writes pass unread byte
// - mode field 0100 selects select-controlled slave
// - select low enables shifting and drives output
// - select high releases output, even mid-byte, one ref_clk after the synchronised select
// - select high or disable clears bit counter
// - master-mode sleep freeze not applicable here
// - msb out first, lsb in
// - write during shift discarded, sets collision flag
// - received byte sets full, read clears it
module sspi_slave
   import sspi_pkg::*;
#(
   parameter int DATA_W = SSPI_DATA_W
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire sspi_cfg_t         cfg,
   input  wire logic              sleep_req,
   input  wire logic              irq_enable,
   input  wire logic              sck_in,
   input  wire logic              sdi_in,
   input  wire logic              ss_n_in,
   output logic                   sdo_out,
   output logic                   sdo_oe,
   input  wire logic              wr_valid,
   input  wire logic [DATA_W-1:0] wr_data,
   output logic                   wr_ready,
   input  wire logic              rd_ready,
   output logic                   rd_valid,
   output logic       [DATA_W-1:0] rd_data,
   input  wire logic              flag_clear_irq,
   input  wire logic              flag_clear_collision,
   output sspi_status_t           status,
   output logic                   wake
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // sampling sck at 250 MHz stands in for the pin-clocked shifter;
   // the shifter never looks at sleep_req, so it runs on in sleep
   logic [1:0] sck_s, sdi_s, ss_s;
   logic       sck_d;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sck_s <= 2'h0;
         sdi_s <= 2'h0;
         ss_s  <= 2'h3;
         sck_d <= 1'b0;
      end else begin
         sck_s <= {sck_s[0], sck_in};
         sdi_s <= {sdi_s[0], sdi_in};
         ss_s  <= {ss_s[0], ss_n_in};
         sck_d <= sck_s[1];
      end
   end

   logic sck_lvl, ss_lvl, sdi_lvl;
   assign sck_lvl = sck_s[1] ^ cfg.clk_polarity_sel;
   assign ss_lvl  = ss_s[1];
   assign sdi_lvl = sdi_s[1];

   logic ss_mode, slave_mode, sel_ok, edge_lead, edge_trail, sample_edge, out_edge;
   assign ss_mode    = cfg.port_mode_field == SSPI_MODE_SLAVE_SS;
   // master modes are not served: the shifter simply holds its state there
   assign slave_mode = ss_mode || cfg.port_mode_field == SSPI_MODE_SLAVE;
   assign sel_ok     = cfg.port_enable_bit && slave_mode && !(ss_mode && ss_lvl);
   assign edge_lead  = (sck_s[1] != sck_d) && (sck_lvl == 1'b1);
   assign edge_trail = (sck_s[1] != sck_d) && (sck_lvl == 1'b0);
   // edge bit set: sample on the return edge, drive on the active edge
   assign sample_edge = cfg.clk_edge_sel ? edge_trail : edge_lead;
   assign out_edge    = cfg.clk_edge_sel ? edge_lead : edge_trail;

   // ------------------------------------------------------------
   // shifter
   // ------------------------------------------------------------
   logic [DATA_W-1:0]     shift_register;
   logic [SSPI_CNT_W-1:0] bit_cnt;
   logic                  byte_done, busy;
   logic                  tx_load;
   logic [DATA_W-1:0]     tx_byte;
   assign busy      = bit_cnt != SSPI_CNT_ZERO;
   assign byte_done = sel_ok && sample_edge && bit_cnt == SSPI_CNT_LAST;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bit_cnt        <= SSPI_CNT_ZERO;
         shift_register <= SSPI_BYTE_ZERO;
      end else if (!cfg.port_enable_bit || (ss_mode && ss_lvl)) begin
         bit_cnt <= SSPI_CNT_ZERO;
      end else if (sel_ok) begin
         if (tx_load) begin
            shift_register <= tx_byte;
         end
         if (sample_edge) begin
            bit_cnt <= bit_cnt + 3'h1;
            // keep received bits so the byte goes back out next group
            shift_register <= {shift_register[DATA_W-2:0], sdi_lvl};
         end
      end
   end

   // ------------------------------------------------------------
   // data out, tristate
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sdo_out <= 1'b0;
         sdo_oe  <= 1'b0;
      end else begin
         sdo_oe <= sel_ok;
         if (!sel_ok || out_edge || !busy) begin
            sdo_out <= shift_register[DATA_W-1];
         end
      end
   end

   // ------------------------------------------------------------
   // write side: two-entry buffer feeding the shifter
   // ------------------------------------------------------------
   logic [DATA_W-1:0] tx_mem [SSPI_BUF_DEPTH];
   logic [1:0]        tx_cnt;
   logic              tx_wp, tx_rp, write_collision_flag, wr_take, wr_hit;
   logic              buffer_full_flag;
   assign wr_hit  = wr_valid && wr_ready;
   assign wr_take = wr_hit && !busy && !write_collision_flag
                    && (!buffer_full_flag || cfg.buffer_overwrite_en);
   assign tx_load = tx_cnt != 2'h0 && !busy && !sample_edge;
   assign tx_byte = tx_mem[tx_rp];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_cnt   <= 2'h0;
         tx_wp    <= 1'b0;
         tx_rp    <= 1'b0;
         wr_ready <= 1'b1;
      end else begin
         if (wr_take) begin
            tx_mem[tx_wp] <= wr_data;
            tx_wp         <= ~tx_wp;
         end
         if (tx_load && sel_ok) begin
            tx_rp <= ~tx_rp;
         end
         tx_cnt   <= tx_cnt + {1'b0, wr_take} - {1'b0, tx_load && sel_ok};
         wr_ready <= (tx_cnt + {1'b0, wr_take} - {1'b0, tx_load && sel_ok}) < 2'h2;
      end
   end

   // ------------------------------------------------------------
   // read side: two-entry buffer and flags
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rx_mem [SSPI_BUF_DEPTH];
   logic [1:0]        rx_cnt;
   logic              rx_wp, rx_rp, rx_push, rx_pop, port_irq_flag;
   logic [DATA_W-1:0] rx_byte;
   assign rx_byte = {shift_register[DATA_W-2:0], sdi_lvl};
   assign rx_push = byte_done && (rx_cnt < 2'h2);
   assign rx_pop  = rd_valid && rd_ready;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_cnt <= 2'h0;
         rx_wp  <= 1'b0;
         rx_rp  <= 1'b0;
      end else begin
         if (rx_push) begin
            rx_mem[rx_wp] <= rx_byte;
            rx_wp         <= ~rx_wp;
         end
         if (rx_pop) begin
            rx_rp <= ~rx_rp;
         end
         rx_cnt <= rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_data  <= SSPI_BYTE_ZERO;
      end else begin
         rd_valid <= (rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop}) != 2'h0;
         rd_data  <= rx_pop ? rx_mem[~rx_rp] : rx_mem[rx_rp];
         if (rx_cnt == 2'h0 || (rx_pop && rx_cnt == 2'h1)) begin
            rd_data <= rx_byte;
         end
      end
   end

   // set beats clear on every flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         buffer_full_flag     <= 1'b0;
         write_collision_flag <= 1'b0;
         port_irq_flag        <= 1'b0;
      end else begin
         if (byte_done) begin
            buffer_full_flag <= 1'b1;
         end else if (rx_pop) begin
            buffer_full_flag <= 1'b0;
         end
         if (wr_hit && busy) begin
            write_collision_flag <= 1'b1;
         end else if (flag_clear_collision) begin
            write_collision_flag <= 1'b0;
         end
         if (byte_done) begin
            port_irq_flag <= 1'b1;
         end else if (flag_clear_irq) begin
            port_irq_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status <= '0;
         wake   <= 1'b0;
      end else begin
         status <= '{port_irq_flag: port_irq_flag, buffer_full_flag: buffer_full_flag,
                     write_collision_flag: write_collision_flag, busy: busy};
         wake   <= sleep_req && irq_enable && byte_done;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_last_bit;
      sel_ok && sample_edge && bit_cnt == SSPI_CNT_LAST;
   endsequence

   a_irq_on_byte: assert property (@(posedge ref_clk) disable iff (rst)
      s_last_bit |=> port_irq_flag)
      else $error("irq flag not set after byte");
   a_full_on_byte: assert property (@(posedge ref_clk) disable iff (rst)
      s_last_bit |=> buffer_full_flag)
      else $error("full flag not set after byte");
   a_release_out: assert property (@(posedge ref_clk) disable iff (rst)
      (ss_mode && ss_lvl) |=> !sdo_oe)
      else $error("output driven while deselected");
   a_drive_out: assert property (@(posedge ref_clk) disable iff (rst)
      sel_ok |=> sdo_oe)
      else $error("output not driven while selected");
   a_cnt_reset: assert property (@(posedge ref_clk) disable iff (rst)
      !cfg.port_enable_bit |=> bit_cnt == SSPI_CNT_ZERO)
      else $error("counter not cleared on disable");
   a_ignore_clk: assert property (@(posedge ref_clk) disable iff (rst)
      (ss_mode && ss_lvl) |=> $stable(shift_register))
      else $error("shifted while deselected");
   a_coll_set: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_hit && busy) |=> write_collision_flag && !$past(wr_take))
      else $error("collision not flagged");
   a_shift_lsb: assert property (@(posedge ref_clk) disable iff (rst)
      (sel_ok && sample_edge && !tx_load) |=> shift_register[0] == $past(sdi_lvl))
      else $error("bit not entered at lsb");
endmodule
